// ===== inc/imre_pkg.sv
// Constants, register map and state type of the I2C master read engine.
package imre_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ = 125000;
	localparam int MS_CYC = CLK_KHZ;
	localparam int BUS_WAIT_MS = 1000;
	localparam int BUS_WAIT_CYC = BUS_WAIT_MS * MS_CYC;
	// ----------------------------------------------------------------
	// Supported bit rates in kHz and quarter bit times in cycles
	// ----------------------------------------------------------------
	localparam int STD_HI_KHZ = 400;
	localparam int STD_LO_KHZ = 100;
	localparam int FAST_HI_KHZ = 3400;
	localparam int FAST_LO_KHZ = 1700;
	localparam logic [15:0] Q_STD_HI = 16'((CLK_KHZ + 4 * STD_HI_KHZ - 1) / (4 * STD_HI_KHZ));
	localparam logic [15:0] Q_STD_LO = 16'((CLK_KHZ + 4 * STD_LO_KHZ - 1) / (4 * STD_LO_KHZ));
	localparam logic [15:0] Q_FAST_HI = 16'((CLK_KHZ + 4 * FAST_HI_KHZ - 1) / (4 * FAST_HI_KHZ));
	localparam logic [15:0] Q_FAST_LO = 16'((CLK_KHZ + 4 * FAST_LO_KHZ - 1) / (4 * FAST_LO_KHZ));
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_POLL = 8'h08;
	localparam logic [7:0] OFS_RATE = 8'h0C;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [7:0] OFS_DATA = 8'h18;
	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int CFG_A10 = 0;
	localparam int CFG_FAST = 1;
	localparam int CFG_CODE_LSB = 2;
	localparam int CTRL_GO = 0;
	localparam int CTRL_LEN_LSB = 8;
	localparam int RATE_FAST_LSB = 16;
	localparam int STAT_FLAG_LSB = 1;
	localparam int STAT_RXV = 8;
	localparam logic [2:0] CODE_RST = 3'h1;
	localparam logic [15:0] STD_RATE_RST = 16'h0064;
	localparam logic [15:0] FAST_RATE_RST = 16'h06A4;
	localparam logic [9:0] ADDR_RST = 10'h000;
	localparam logic [15:0] POLL_RST = 16'h0000;
	// Flag indices inside the status flag vector.
	localparam int F_DONE = 0;
	localparam int F_BUS = 1;
	localparam int F_ARB = 2;
	localparam int F_NACK = 3;
	localparam int F_CFG = 4;
	localparam int F_RATE = 5;
	localparam int F_WARN = 6;
	// ----------------------------------------------------------------
	// Bus byte encodings
	// ----------------------------------------------------------------
	localparam logic [4:0] HS_PREFIX = 5'h01;
	localparam logic [4:0] TEN_PREFIX = 5'h1E;
	localparam logic DIR_READ = 1'b1;
	localparam logic DIR_WRITE = 1'b0;
	typedef enum logic [3:0] {
		S_IDLE, S_FREE, S_START, S_TXBIT, S_TXACK,
		S_RXBIT, S_RXHOLD, S_RXACK, S_STOP
	} imre_state_t;
endpackage

// ===== rtl/imre_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain.
module imre_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// Reset to released (high) line levels.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			meta_ff <= '1;
			q_ff <= '1;
		end else begin
			meta_ff <= d_i;
			q_ff <= meta_ff;
		end
	end

	assign q_o = q_ff;
endmodule

// ===== rtl/imre_top.sv
// I2C master read engine with APB register access.
// Summary of operation
// - Address in 7-bit or 10-bit mode, default 7.
// - Slave address resets to zero.
// - 7-bit address byte is address plus direction.
// - Engine inserts the direction bit itself.
// - Poll timeout in ms, zero disables polling.
// - Repeat address until ack or timeout.
// - 10-bit with polling rejects the request.
// - Fast mode optional, off by default.
// - Fast bit rate defaults to 1700 kHz.
// - Unsupported rate rounds down with warning; a rate below the lowest supported rate rejects the request.
// - Three-bit entry code, default one.
// - Read exactly the requested byte count.
// - Ack every byte except the last.
// - Wait for free bus, error after 1 s.
// - Lost arbitration abandons with error.
// - Address not acked triggers polling.
// - Finish with a stop condition.
// - Standard rate 100 kHz, used for entry code.
//
// The APB interface to the registers and the placing of the registers were decided locally.
module imre_top #(
	parameter int BUS_WAIT_CYC = imre_pkg::BUS_WAIT_CYC,
	parameter int MS_CYC = imre_pkg::MS_CYC
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o
);
	// ----------------------------------------------------------------
	// Line synchronisers
	// ----------------------------------------------------------------
	logic [1:0] lines_s;
	wire scl_s = lines_s[1];
	wire sda_s = lines_s[0];
	imre_sync #(.W(2)) u_sync (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.d_i({scl_i, sda_i}),
		.q_o(lines_s)
	);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	imre_pkg::imre_state_t state_ff, nxt_state;
	logic pready_ff, pslverr_ff;
	logic [31:0] prdata_ff;
	logic cfg_a10_ff, fast_on_ff;
	logic [2:0] code_ff;
	logic [9:0] addr_ff;
	logic [15:0] poll_ff, std_rate_ff, fast_rate_ff, qcnt_ff;
	logic [7:0] len_ff, left_ff, nxt_left, shift_ff, rx_data_ff, rx_cnt_ff;
	logic rx_valid_ff;
	logic [6:0] flags_ff;
	logic [1:0] phase_ff, step_ff, nxt_step;
	logic [2:0] bit_ff, nxt_bit;
	logic first_ff, nxt_first, fast_ff, nxt_fast, retry_ff, nxt_retry;
	logic [26:0] wait_cnt_ff;
	logic [16:0] ms_pre_ff;
	logic [15:0] ms_cnt_ff;
	logic scl_oe_n_ff, sda_oe_n_ff, scl_o_ff, sda_o_ff;
	logic sda_d_ff, bus_busy_ff;
	logic scl_rel, sda_rel, ev_bus, ev_arb, ev_nack, ev_done;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire apb_acc = psel_i & penable_i;
	wire apb_done = apb_acc & pready_ff;
	wire apb_wr = apb_done & pwrite_i;
	wire hit_cfg = paddr_i == imre_pkg::OFS_CFG;
	wire hit_addr = paddr_i == imre_pkg::OFS_ADDR;
	wire hit_poll = paddr_i == imre_pkg::OFS_POLL;
	wire hit_rate = paddr_i == imre_pkg::OFS_RATE;
	wire hit_ctrl = paddr_i == imre_pkg::OFS_CTRL;
	wire hit_stat = paddr_i == imre_pkg::OFS_STAT;
	wire hit_data = paddr_i == imre_pkg::OFS_DATA;
	wire mapped = hit_cfg | hit_addr | hit_poll | hit_rate | hit_ctrl | hit_stat | hit_data;
	wire busy = state_ff != imre_pkg::S_IDLE;
	wire pop = apb_done & ~pwrite_i & hit_data;
	wire [31:0] rd_mux =
		hit_cfg ? {27'h0, code_ff, fast_on_ff, cfg_a10_ff} :
		hit_addr ? {22'h0, addr_ff} :
		hit_poll ? {16'h0, poll_ff} :
		hit_rate ? {fast_rate_ff, std_rate_ff} :
		hit_ctrl ? {16'h0, len_ff, 8'h00} :
		hit_stat ? {23'h0, rx_valid_ff, flags_ff, busy} :
		hit_data ? {24'h0, rx_data_ff} : 32'h0;

	// Each transfer is answered in the second access cycle.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			pready_ff <= apb_acc & ~pready_ff;
			pslverr_ff <= apb_acc & ~pready_ff & ~mapped;
			prdata_ff <= (apb_acc & ~pready_ff) ? rd_mux : prdata_ff;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cfg_a10_ff <= 1'b0;
			fast_on_ff <= 1'b0;
			code_ff <= imre_pkg::CODE_RST;
			addr_ff <= imre_pkg::ADDR_RST;
			poll_ff <= imre_pkg::POLL_RST;
			std_rate_ff <= imre_pkg::STD_RATE_RST;
			fast_rate_ff <= imre_pkg::FAST_RATE_RST;
			len_ff <= 8'h00;
		end else if (apb_wr) begin
			if (hit_cfg) begin
				cfg_a10_ff <= pwdata_i[imre_pkg::CFG_A10];
				fast_on_ff <= pwdata_i[imre_pkg::CFG_FAST];
				code_ff <= pwdata_i[imre_pkg::CFG_CODE_LSB +: 3];
			end
			if (hit_addr)
				addr_ff <= pwdata_i[9:0];
			if (hit_poll)
				poll_ff <= pwdata_i[15:0];
			if (hit_rate) begin
				std_rate_ff <= pwdata_i[15:0];
				fast_rate_ff <= pwdata_i[imre_pkg::RATE_FAST_LSB +: 16];
			end
			if (hit_ctrl && !busy)
				len_ff <= pwdata_i[imre_pkg::CTRL_LEN_LSB +: 8];
		end
	end

	// ----------------------------------------------------------------
	// Rate resolution and request checks
	// ----------------------------------------------------------------
	wire std_hi = std_rate_ff >= 16'(imre_pkg::STD_HI_KHZ);
	wire std_lo = std_rate_ff >= 16'(imre_pkg::STD_LO_KHZ);
	wire fast_hi = fast_rate_ff >= 16'(imre_pkg::FAST_HI_KHZ);
	wire fast_lo = fast_rate_ff >= 16'(imre_pkg::FAST_LO_KHZ);
	wire std_warn = std_hi ? std_rate_ff != 16'(imre_pkg::STD_HI_KHZ)
		: std_rate_ff != 16'(imre_pkg::STD_LO_KHZ);
	wire fast_warn = fast_hi ? fast_rate_ff != 16'(imre_pkg::FAST_HI_KHZ)
		: fast_rate_ff != 16'(imre_pkg::FAST_LO_KHZ);
	wire rate_err = ~std_lo | (fast_on_ff & ~fast_lo);
	wire rate_warn = std_warn | (fast_on_ff & fast_warn);
	wire cfg_err = cfg_a10_ff & (poll_ff != 16'h0000);
	wire go = apb_wr & hit_ctrl & pwdata_i[imre_pkg::CTRL_GO] & ~busy;
	wire start_ok = go & ~cfg_err & ~rate_err;
	wire [15:0] std_q = std_hi ? imre_pkg::Q_STD_HI : imre_pkg::Q_STD_LO;
	wire [15:0] fast_q = fast_hi ? imre_pkg::Q_FAST_HI : imre_pkg::Q_FAST_LO;
	wire [15:0] qtr = fast_ff ? fast_q : std_q;

	// ----------------------------------------------------------------
	// Symbol timing
	// ----------------------------------------------------------------
	wire sym_st = state_ff inside {imre_pkg::S_START, imre_pkg::S_TXBIT,
		imre_pkg::S_TXACK, imre_pkg::S_RXBIT, imre_pkg::S_RXACK, imre_pkg::S_STOP};
	wire stretch = (phase_ff == 2'h1) & scl_rel & ~scl_s;
	wire tick = sym_st & (qcnt_ff >= qtr - 16'h0001) & ~stretch;
	wire sym_end = tick & (phase_ff == 2'h3);
	wire samp = tick & (phase_ff == 2'h2);
	wire phase_mid = phase_ff[0] ^ phase_ff[1];
	wire arb_lost = samp & (state_ff == imre_pkg::S_TXBIT) & sda_rel & ~sda_s;
	wire bus_free = ~bus_busy_ff & scl_s & sda_s;
	wire poll_exp = ms_cnt_ff >= poll_ff;
	wire acked = ~shift_ff[0];
	wire ack_now = left_ff > 8'h01;
	wire store = (state_ff == imre_pkg::S_RXHOLD) & ~rx_valid_ff;
	wire [7:0] tx_byte =
		(step_ff == 2'h0) ? {imre_pkg::HS_PREFIX, code_ff} :
		(step_ff == 2'h2) ? addr_ff[7:0] :
		cfg_a10_ff ? {imre_pkg::TEN_PREFIX, addr_ff[9:8],
			(step_ff == 2'h3) ? imre_pkg::DIR_READ : imre_pkg::DIR_WRITE} :
		{addr_ff[6:0], imre_pkg::DIR_READ};

	// Line drive per symbol phase; a one releases the line.
	always_comb begin
		scl_rel = 1'b1;
		sda_rel = 1'b1;
		case (state_ff)
			imre_pkg::S_START: begin
				scl_rel = (phase_ff == 2'h0) ? first_ff : (phase_ff != 2'h3);
				sda_rel = ~phase_ff[1];
			end
			imre_pkg::S_TXBIT: begin
				scl_rel = phase_mid;
				sda_rel = tx_byte[bit_ff];
			end
			imre_pkg::S_TXACK, imre_pkg::S_RXBIT: scl_rel = phase_mid;
			imre_pkg::S_RXACK: begin
				scl_rel = phase_mid;
				sda_rel = ~ack_now;
			end
			imre_pkg::S_RXHOLD: scl_rel = 1'b0;
			imre_pkg::S_STOP: begin
				scl_rel = phase_ff != 2'h0;
				sda_rel = phase_ff[1];
			end
			default: ;
		endcase
	end

	// ----------------------------------------------------------------
	// Transaction sequencer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_step = step_ff;
		nxt_bit = bit_ff;
		nxt_left = left_ff;
		nxt_first = first_ff;
		nxt_fast = fast_ff;
		nxt_retry = retry_ff;
		ev_bus = 1'b0;
		ev_arb = 1'b0;
		ev_nack = 1'b0;
		ev_done = 1'b0;
		case (state_ff)
			imre_pkg::S_IDLE: begin
				if (start_ok)
					nxt_state = imre_pkg::S_FREE;
			end
			imre_pkg::S_FREE: begin
				if (bus_free) begin
					nxt_state = imre_pkg::S_START;
					nxt_first = 1'b1;
					nxt_step = fast_on_ff ? 2'h0 : 2'h1;
				end else if (wait_cnt_ff == 27'(BUS_WAIT_CYC - 1)) begin
					ev_bus = 1'b1;
					nxt_state = imre_pkg::S_IDLE;
				end
			end
			imre_pkg::S_START: begin
				if (sym_end) begin
					nxt_state = imre_pkg::S_TXBIT;
					nxt_bit = 3'h7;
					nxt_first = 1'b0;
				end
			end
			imre_pkg::S_TXBIT: begin
				if (arb_lost) begin
					ev_arb = 1'b1;
					nxt_fast = 1'b0;
					nxt_retry = 1'b0;
					nxt_state = imre_pkg::S_IDLE;
				end else if (sym_end) begin
					nxt_bit = bit_ff - 3'h1;
					if (bit_ff == 3'h0)
						nxt_state = imre_pkg::S_TXACK;
				end
			end
			imre_pkg::S_TXACK: begin
				if (sym_end) begin
					nxt_bit = 3'h7;
					nxt_left = len_ff;
					if (step_ff == 2'h0) begin
						nxt_fast = 1'b1;
						nxt_step = 2'h1;
						nxt_state = imre_pkg::S_START;
					end else if (!acked) begin
						if (step_ff == 2'h1 && poll_ff != 16'h0000 && !poll_exp)
							nxt_retry = 1'b1;
						else
							ev_nack = 1'b1;
						nxt_state = imre_pkg::S_STOP;
					end else if (step_ff == 2'h1 && cfg_a10_ff) begin
						nxt_step = 2'h2;
						nxt_state = imre_pkg::S_TXBIT;
					end else if (step_ff == 2'h2) begin
						nxt_step = 2'h3;
						nxt_state = imre_pkg::S_START;
					end else begin
						nxt_state = (len_ff == 8'h00) ? imre_pkg::S_STOP : imre_pkg::S_RXBIT;
					end
				end
			end
			imre_pkg::S_RXBIT: begin
				if (sym_end) begin
					nxt_bit = bit_ff - 3'h1;
					if (bit_ff == 3'h0)
						nxt_state = imre_pkg::S_RXHOLD;
				end
			end
			imre_pkg::S_RXHOLD: begin
				if (store)
					nxt_state = imre_pkg::S_RXACK;
			end
			imre_pkg::S_RXACK: begin
				if (sym_end) begin
					nxt_left = left_ff - 8'h01;
					nxt_bit = 3'h7;
					nxt_state = ack_now ? imre_pkg::S_RXBIT : imre_pkg::S_STOP;
				end
			end
			imre_pkg::S_STOP: begin
				if (sym_end) begin
					nxt_fast = 1'b0;
					nxt_retry = 1'b0;
					ev_done = ~retry_ff;
					nxt_state = retry_ff ? imre_pkg::S_FREE : imre_pkg::S_IDLE;
				end
			end
			default: nxt_state = imre_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state_ff <= imre_pkg::S_IDLE;
			step_ff <= 2'h1;
			bit_ff <= 3'h7;
			left_ff <= 8'h00;
			first_ff <= 1'b0;
			fast_ff <= 1'b0;
			retry_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			step_ff <= nxt_step;
			bit_ff <= nxt_bit;
			left_ff <= nxt_left;
			first_ff <= nxt_first;
			fast_ff <= nxt_fast;
			retry_ff <= nxt_retry;
		end
	end

	// ----------------------------------------------------------------
	// Counters, sampling and line outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			qcnt_ff <= 16'h0000;
			phase_ff <= 2'h0;
			wait_cnt_ff <= 27'h0;
			ms_pre_ff <= 17'h0;
			ms_cnt_ff <= 16'h0000;
		end else begin
			qcnt_ff <= (tick || !sym_st || stretch) ? 16'h0000 : qcnt_ff + 16'h0001;
			phase_ff <= !sym_st ? 2'h0 : phase_ff + {1'b0, tick};
			wait_cnt_ff <= (state_ff == imre_pkg::S_FREE) ? wait_cnt_ff + 27'h1 : 27'h0;
			ms_pre_ff <= (!busy || ms_pre_ff == 17'(MS_CYC - 1)) ? 17'h0 : ms_pre_ff + 17'h1;
			if (!busy)
				ms_cnt_ff <= 16'h0000;
			else if (ms_pre_ff == 17'(MS_CYC - 1) && ms_cnt_ff != 16'hFFFF)
				ms_cnt_ff <= ms_cnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			shift_ff <= 8'h00;
			sda_d_ff <= 1'b1;
			bus_busy_ff <= 1'b0;
			scl_oe_n_ff <= 1'b1;
			sda_oe_n_ff <= 1'b1;
			scl_o_ff <= 1'b0;
			sda_o_ff <= 1'b0;
		end else begin
			if (samp)
				shift_ff <= {shift_ff[6:0], sda_s};
			sda_d_ff <= sda_s;
			if (scl_s && sda_d_ff && !sda_s)
				bus_busy_ff <= 1'b1;
			else if (scl_s && !sda_d_ff && sda_s)
				bus_busy_ff <= 1'b0;
			scl_oe_n_ff <= scl_rel;
			sda_oe_n_ff <= sda_rel;
			scl_o_ff <= 1'b0;
			sda_o_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Received data and status flags
	// ----------------------------------------------------------------
	wire [6:0] ev_flags = {go & rate_warn & ~cfg_err & ~rate_err, go & rate_err,
		go & cfg_err, ev_nack, ev_arb, ev_bus, ev_done};

	// A new event wins over the clear that a new request brings.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			flags_ff <= 7'h00;
			rx_valid_ff <= 1'b0;
			rx_data_ff <= 8'h00;
			rx_cnt_ff <= 8'h00;
		end else begin
			flags_ff <= (flags_ff & {7{~go}}) | ev_flags;
			rx_valid_ff <= store | (rx_valid_ff & ~pop);
			rx_data_ff <= store ? shift_ff : rx_data_ff;
			rx_cnt_ff <= go ? 8'h00 : rx_cnt_ff + {7'h0, store};
		end
	end

	assign prdata_o = prdata_ff;
	assign pready_o = pready_ff;
	assign pslverr_o = pslverr_ff;
	assign scl_o = scl_o_ff;
	assign sda_o = sda_o_ff;
	assign scl_oe_n_o = scl_oe_n_ff;
	assign sda_oe_n_o = sda_oe_n_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	property p_reject;
		go && cfg_err |=> state_ff == imre_pkg::S_IDLE && flags_ff[imre_pkg::F_CFG];
	endproperty
	a_reject: assert property (p_reject) else $error("Bad request not rejected.");

	property p_addr7;
		state_ff == imre_pkg::S_TXBIT && step_ff == 2'h1 && !cfg_a10_ff
			|-> tx_byte == {addr_ff[6:0], 1'b1};
	endproperty
	a_addr7: assert property (p_addr7) else $error("Address byte wrong.");

	property p_nack_last;
		state_ff == imre_pkg::S_RXACK && $past(state_ff) == imre_pkg::S_RXACK
			&& left_ff == 8'h01 |-> sda_oe_n_o;
	endproperty
	a_nack_last: assert property (p_nack_last) else $error("Last byte acked.");

	property p_ack_more;
		state_ff == imre_pkg::S_RXACK && $past(state_ff) == imre_pkg::S_RXACK
			&& left_ff > 8'h01 |-> !sda_oe_n_o;
	endproperty
	a_ack_more: assert property (p_ack_more) else $error("Byte not acked.");

	property p_done_stop;
		$rose(flags_ff[imre_pkg::F_DONE]) |-> $past(state_ff) == imre_pkg::S_STOP;
	endproperty
	a_done_stop: assert property (p_done_stop) else $error("Done without stop.");

	property p_arb;
		arb_lost |=> state_ff == imre_pkg::S_IDLE && flags_ff[imre_pkg::F_ARB]
			##1 scl_oe_n_o && sda_oe_n_o;
	endproperty
	a_arb: assert property (p_arb) else $error("Arbitration loss mishandled.");

	property p_bus;
		state_ff == imre_pkg::S_FREE && !bus_free && wait_cnt_ff == 27'(BUS_WAIT_CYC - 1)
			|=> flags_ff[imre_pkg::F_BUS] && state_ff == imre_pkg::S_IDLE;
	endproperty
	a_bus: assert property (p_bus) else $error("Bus wait not ended.");

	property p_count;
		$rose(flags_ff[imre_pkg::F_DONE]) && !flags_ff[imre_pkg::F_NACK]
			|-> rx_cnt_ff == len_ff;
	endproperty
	a_count: assert property (p_count) else $error("Byte count wrong.");

	property p_nopoll;
		state_ff == imre_pkg::S_TXACK && sym_end && step_ff == 2'h1 && !acked
			&& poll_ff == 16'h0000 |=> flags_ff[imre_pkg::F_NACK] && !retry_ff;
	endproperty
	a_nopoll: assert property (p_nopoll) else $error("Poll not disabled.");

	property p_poll;
		state_ff == imre_pkg::S_TXACK && sym_end && step_ff == 2'h1 && !acked
			&& poll_ff != 16'h0000 && !poll_exp |=> retry_ff && state_ff == imre_pkg::S_STOP;
	endproperty
	a_poll: assert property (p_poll) else $error("Poll retry missing.");

	property p_hs;
		state_ff == imre_pkg::S_TXACK && sym_end && step_ff == 2'h0
			|=> state_ff == imre_pkg::S_START && fast_ff;
	endproperty
	a_hs: assert property (p_hs) else $error("No restart after entry code.");

	c_done: cover property ($rose(flags_ff[imre_pkg::F_DONE]) && len_ff > 8'h01);
	c_hs: cover property (state_ff == imre_pkg::S_RXBIT && fast_ff);
	c_retry: cover property ($rose(retry_ff));
endmodule

// ===== testbench/imre_slave.sv
// Behavioural I2C slave that answers reads with an incrementing byte stream.
module imre_slave #(
	parameter logic [6:0] ADDR = 7'h5A,
	parameter logic [7:0] FIRST = 8'hC3
) (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic ack_en_i,
	output logic sda_low_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh = 8'h00;
	logic [7:0] tx = FIRST;
	logic hdr = 1'b0;
	logic rd = 1'b0;
	int bitn = 0;
	int stops = 0;
	logic [7:0] hdr_q[$];
	logic ack_q[$];
	initial sda_low_o = 1'b0;
	always @(negedge sda_i) if (scl_i === 1'b1) begin
		bitn = 0;
		hdr = 1'b1;
		rd = 1'b0;
		tx = FIRST;
	end
	always @(posedge sda_i) if (scl_i === 1'b1) begin
		stops++;
		hdr = 1'b0;
		rd = 1'b0;
	end
	always @(posedge scl_i) begin
		if (bitn < 8)
			sh = {sh[6:0], sda_i};
		else if (hdr)
			hdr = 1'b0;
		else if (rd) begin
			ack_q.push_back(sda_i);
			rd = ~sda_i;
			tx = tx + 8'h01;
		end
		bitn = (bitn == 8) ? 0 : bitn + 1;
	end
	// A released line is left to the pull-up, so a silent slave never holds SDA.
	always @(negedge scl_i) begin
		sda_low_o = 1'b0;
		if (bitn == 8 && hdr) begin
			hdr_q.push_back(sh);
			rd = (sh[7:1] == ADDR) && sh[0] && ack_en_i;
			sda_low_o = rd;
		end else if (bitn < 8 && rd && !hdr)
			sda_low_o = ~tx[7 - bitn];
	end
endmodule

// ===== testbench/tb_i2c_master_read_engine.sv
// Self-checking bench for the I2C master read engine.
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_i2c_master_read_engine;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, last_err, scl_oe_n, sda_oe_n, slv_low, scl_drv, sda_drv;
	logic other_low = 1'b0;
	logic ack_en = 1'b1;
	wire scl_w;
	wire sda_w;
	int error_cnt = 0;
	int checked = 0;
	logic [31:0] st, d;
	logic [7:0] rx_q[$];
	assign scl_w = (scl_oe_n !== 1'b0);
	assign sda_w = (sda_oe_n !== 1'b0) && !slv_low && !other_low;
	imre_top #(.BUS_WAIT_CYC(2000), .MS_CYC(200)) imre_top_i (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .scl_i(scl_w), .scl_o(scl_drv),
		.scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_drv), .sda_oe_n_o(sda_oe_n));
	imre_slave imre_slave_i (.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en),
		.sda_low_o(slv_low));
	initial forever #4 sys_clk_i = ~sys_clk_i;
	task automatic results;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk_i);
		end while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, d);
		`CHK(d, e)
	endtask
	task automatic go(input logic [7:0] len);
		rx_q.delete();
		imre_slave_i.hdr_q.delete();
		imre_slave_i.ack_q.delete();
		imre_slave_i.stops = 0;
		apb(1'b1, imre_pkg::OFS_CTRL, {16'h0000, len, 8'h01}, d);
		do begin
			apb(1'b0, imre_pkg::OFS_STAT, 32'h0, st);
			if (st[8] === 1'b1) begin
				apb(1'b0, imre_pkg::OFS_DATA, 32'h0, d);
				rx_q.push_back(d[7:0]);
			end
		end while (st[0] !== 1'b0);
	endtask
	initial begin
		repeat (80000) @(posedge sys_clk_i);
		error_cnt++;
		results();
	end
	initial begin
		repeat (6) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		@(posedge sys_clk_i);
		chk_rd(imre_pkg::OFS_CFG, 32'h0000_0004);
		chk_rd(imre_pkg::OFS_ADDR, 32'h0);
		chk_rd(imre_pkg::OFS_POLL, 32'h0);
		chk_rd(imre_pkg::OFS_RATE, 32'h06A4_0064);
		chk_rd(8'h1C, 32'h0);
		`CHK(last_err, 1'b1)
		apb(1'b1, imre_pkg::OFS_ADDR, {24'h0, 8'hB4 >> 1}, d);
		apb(1'b1, imre_pkg::OFS_RATE, 32'h0D48_01F4, d);
		go(8'd3);
		`CHK(st, 32'h0000_0082)
		`CHK(imre_slave_i.hdr_q[0], 8'hB5)
		`CHK(rx_q.size(), 3)
		`CHK({rx_q[0], rx_q[1], rx_q[2]}, 24'hC3C4C5)
		`CHK({imre_slave_i.ack_q[0], imre_slave_i.ack_q[1], imre_slave_i.ack_q[2]}, 3'b001)
		`CHK(imre_slave_i.stops, 1)
		apb(1'b1, imre_pkg::OFS_RATE, 32'h0D48_0190, d);
		ack_en <= 1'b0;
		go(8'd1);
		`CHK(st, 32'h0000_0012)
		`CHK(imre_slave_i.hdr_q.size(), 1)
		apb(1'b1, imre_pkg::OFS_POLL, 32'd40, d);
		go(8'd1);
		`CHK(st, 32'h0000_0012)
		`CHK(imre_slave_i.hdr_q.size() > 1, 1'b1)
		apb(1'b1, imre_pkg::OFS_CFG, 32'h0000_0005, d);
		go(8'd1);
		`CHK(st, 32'h0000_0020)
		`CHK(imre_slave_i.hdr_q.size(), 0)
		apb(1'b1, imre_pkg::OFS_POLL, 32'h0, d);
		apb(1'b1, imre_pkg::OFS_ADDR, 32'h0000_015A, d);
		go(8'd1);
		`CHK(imre_slave_i.hdr_q[0], 8'hF2)
		`CHK(st, 32'h0000_0012)
		apb(1'b1, imre_pkg::OFS_ADDR, 32'h0000_005A, d);
		apb(1'b1, imre_pkg::OFS_CFG, 32'h0000_0004, d);
		apb(1'b1, imre_pkg::OFS_RATE, 32'h0D48_0032, d);
		go(8'd1);
		`CHK(st, 32'h0000_0040)
		apb(1'b1, imre_pkg::OFS_RATE, 32'h0D48_0190, d);
		apb(1'b1, imre_pkg::OFS_CFG, 32'h0000_000E, d);
		ack_en <= 1'b1;
		go(8'd1);
		`CHK(st, 32'h0000_0002)
		`CHK({imre_slave_i.hdr_q[0], imre_slave_i.hdr_q[1]}, 16'h0BB5)
		other_low <= 1'b1;
		go(8'd1);
		`CHK(st, 32'h0000_0004)
		other_low <= 1'b0;
		// A second master holds SDA low from the first clocked bit onwards.
		fork
			go(8'd1);
			begin
				wait (scl_oe_n === 1'b0);
				wait (scl_oe_n === 1'b1);
				@(posedge sys_clk_i);
				other_low <= 1'b1;
			end
		join
		other_low <= 1'b0;
		`CHK(st, 32'h0000_0008)
		`CHK({scl_oe_n, sda_oe_n, scl_drv, sda_drv}, 4'hC)
		results();
	end
endmodule
